/* File: dv/dbg_probe.sv */
// debug probe model with the chip-level tdo buffer
`timescale 1ns/1ns
`default_nettype none
module dbg_probe (
   // test port to the core
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   // core tdo and its drive indication
   input  wire logic tdo,
   input  wire logic tdo_float
);
   // pull-up stands in while the buffer floats
   wire tdo_pin = tdo_float ? 1'b1 : tdo;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // tck only runs inside a step, tdo seen just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #3;
      o = tdo_pin;
      tck = 1'b1;
      #3;
      tck = 1'b0;
   endtask
   // tms walk lsb first; tdi toggles so a stale level never passes
   task automatic move(input logic [7:0] seq, input int n);
      logic o;
      for (int i = 0; i < n; i++) step(seq[i], ~tdi, o);
   endtask
   // shift n bits lsb first, then update and idle
   task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
      logic o;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      move(8'h01, 2);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// testbench for the debug test port block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dbg_tap_pkg::*;
   logic        mclk = 0, reset = 1, trst_n = 1, strap = 0, irq_req = 0;
   wire         tck, tms, tdi;
   logic        tdo, tdo_float, sup_bit, dbg_irq;
   logic [31:0] d;
   int          miscompares = 0, check_count = 0;
   always #25 mclk = ~mclk;
   dbg_tap_top u_dbg_tap_top (.mclk(mclk), .reset(reset), .dbg_test_clock_in(tck),
      .dbg_test_reset_n(trst_n), .dbg_test_mode_sel_in(tms), .dbg_test_data_in(tdi),
      .dbg_test_data_out(tdo), .dbg_test_out_float(tdo_float),
      .dbg_irq_supported_strap(strap), .dbg_irq_request(irq_req),
      .dbg_irq_supported_bit(sup_bit), .probe_debug_irq(dbg_irq));
   // controller is built in, so the probe port is wired up
   dbg_probe u_dbg_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_float(tdo_float));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // test reset in mid shift must float tdo at once
   task automatic t_trst;
      u_dbg_probe.move(8'h01, 3);
      #1;
      chk(tdo_float, 0);
      @(posedge mclk) trst_n <= 0;
      #1;
      chk({tdo_float, tdo}, 2'h2);
      @(posedge mclk) trst_n <= 1;
      u_dbg_probe.move(8'h00, 1);
   endtask
   // strap seen in the supported bit and in impl bit 24; bypass delays tdi
   task automatic t_scan(input logic s);
      @(posedge mclk) strap <= s;
      repeat (3) @(posedge mclk);
      chk(sup_bit, s);
      u_dbg_probe.move(8'h03, 4);
      u_dbg_probe.scan(IR_IMPL, IR_W, d);
      chk(d[4:0], 5'h01);
      u_dbg_probe.move(8'h01, 3);
      u_dbg_probe.scan(32'h0, IMPL_W, d);
      chk(d[IMPL_PROBE_DEBUG_IRQ_BIT], s);
      chk(tdo_float, 1);
      // five high tms clocks reset the port and its instruction to IR_RESET, which shifts through the one-bit path
      u_dbg_probe.move(8'h1f, 5);
      u_dbg_probe.move(8'h02, 4);
      u_dbg_probe.scan(32'h1, 2, d);
      chk(d[1:0], 2'h2);
      u_dbg_probe.move(8'h03, 4);
      u_dbg_probe.scan(IR_BYPASS, IR_W, d);
      u_dbg_probe.move(8'h01, 3);
      u_dbg_probe.scan(32'h5, 3, d);
      chk(d[2:0], 3'h2);
   endtask
   task automatic cnt_irq(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (dbg_irq === 1'b1) c++;
      end
   endtask
   // one pulse per rising edge, none while held, none when unsupported
   task automatic t_irq(input logic s);
      int c;
      @(posedge mclk) strap <= s;
      repeat (3) @(posedge mclk);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk) irq_req <= 1;
         cnt_irq(8, c);
         chk(c, s);
         cnt_irq(8, c);
         chk(c, 0);
         @(posedge mclk) irq_req <= 0;
         repeat (4) @(posedge mclk);
      end
   endtask
   initial begin
      trst_n <= 0;
      repeat (10) @(posedge mclk);
      reset <= 0;
      trst_n <= 1;
      #5;
      chk({tdo_float, tdo}, 2'h2);
      u_dbg_probe.move(8'h00, 1);
      t_trst();
      t_scan(1);
      t_scan(0);
      t_irq(1);
      t_irq(0);
      close_out();
   end
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
endmodule
`default_nettype wire

/* File: rtl/dbg_tap_ctrl.sv */
// test access port controller on the test clock
`timescale 1ns/1ns
`default_nettype none
module dbg_tap_ctrl
   import dbg_tap_pkg::*;
(
   // test port pins
   input  wire logic     dbg_test_clock_in,
   input  wire logic     dbg_test_reset_n,
   input  wire logic     dbg_test_mode_sel_in,
   input  wire logic     dbg_test_data_in,
   // implementation register bit, already in this domain
   input  wire logic     impl_probe_debug_irq_sup,
   // outputs to the pins
   output var  tap_out_t tap_out
);

   tap_state_t              state_ff;
   tap_state_t              nxt_state;
   logic [IR_W-1:0]         ir_ff;
   logic [IR_W-1:0]         ir_shift_ff;
   logic [IMPL_W-1:0]       dr_ff;
   logic                    tdo_ff;
   logic                    float_ff;

   wire tms = dbg_test_mode_sel_in;
   wire sel_impl = (ir_ff == IR_IMPL);
   wire [IMPL_W-1:0] impl_word = {{(IMPL_W-IMPL_PROBE_DEBUG_IRQ_BIT-1){1'b0}}, impl_probe_debug_irq_sup,
                                  {IMPL_PROBE_DEBUG_IRQ_BIT{1'b0}}};
   wire shifting = (state_ff == TAP_SHIFT_DR) || (state_ff == TAP_SHIFT_IR);
   wire shift_bit = (state_ff == TAP_SHIFT_IR) ? ir_shift_ff[0] : dr_ff[0];

   // sixteen-state sequence on tms
   always_comb begin
      case (state_ff)
         TAP_RESET:    nxt_state = tms ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   nxt_state = tms ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nxt_state = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nxt_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nxt_state = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   nxt_state = tms ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nxt_state = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nxt_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nxt_state = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
         default:      nxt_state = TAP_RESET;
      endcase
   end

   // asynchronous test reset forces the reset state
   always_ff @(posedge dbg_test_clock_in or negedge dbg_test_reset_n) begin
      if (!dbg_test_reset_n) begin
         state_ff <= TAP_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // instruction and data registers on the rising edge
   always_ff @(posedge dbg_test_clock_in or negedge dbg_test_reset_n) begin
      if (!dbg_test_reset_n) begin
         ir_ff       <= IR_RESET;
         ir_shift_ff <= '0;
         dr_ff       <= '0;
      end else begin
         if (state_ff == TAP_RESET) begin
            ir_ff <= IR_RESET;
         end else if (state_ff == TAP_UPD_IR) begin
            ir_ff <= ir_shift_ff;
         end
         if (state_ff == TAP_CAP_IR) begin
            ir_shift_ff <= {3'h0, IR_CAPTURE};
         end else if (state_ff == TAP_SHIFT_IR) begin
            ir_shift_ff <= {dbg_test_data_in, ir_shift_ff[IR_W-1:1]};
         end
         if (state_ff == TAP_CAP_DR) begin
            dr_ff <= sel_impl ? impl_word : '0;
         end else if (state_ff == TAP_SHIFT_DR) begin
            dr_ff <= sel_impl ? {dbg_test_data_in, dr_ff[IMPL_W-1:1]}
                              : {{(IMPL_W-1){1'b0}}, dbg_test_data_in};
         end
      end
   end

   // output changes on the falling edge so the probe samples it clean
   always_ff @(negedge dbg_test_clock_in or negedge dbg_test_reset_n) begin
      if (!dbg_test_reset_n) begin
         tdo_ff   <= 1'b0;
         float_ff <= 1'b1;
      end else begin
         tdo_ff   <= shifting ? shift_bit : 1'b0;
         float_ff <= !shifting;
      end
   end

   assign tap_out.tdo       = tdo_ff;
   assign tap_out.tdo_float = float_ff;

   // output floats whenever no shift state is active
   float_idle_a: assert property (@(negedge dbg_test_clock_in) disable iff (!dbg_test_reset_n)
      !$past(shifting) |-> tap_out.tdo_float) else $error("tdo driven outside shift");
   // five high tms clocks reach reset from any state
   tms_reset_a: assert property (@(posedge dbg_test_clock_in) disable iff (!dbg_test_reset_n)
      tms [*5] |=> state_ff == TAP_RESET) else $error("tap missed reset");

endmodule
`default_nettype wire

/* File: rtl/dbg_tap_pkg.sv */
// shared constants and types for the debug test port block
package dbg_tap_pkg;

   // test access port controller states, one-hot
   typedef enum logic [15:0] {
      TAP_RESET      = 16'h0001,
      TAP_IDLE       = 16'h0002,
      TAP_SEL_DR     = 16'h0004,
      TAP_CAP_DR     = 16'h0008,
      TAP_SHIFT_DR   = 16'h0010,
      TAP_EXIT1_DR   = 16'h0020,
      TAP_PAUSE_DR   = 16'h0040,
      TAP_EXIT2_DR   = 16'h0080,
      TAP_UPD_DR     = 16'h0100,
      TAP_SEL_IR     = 16'h0200,
      TAP_CAP_IR     = 16'h0400,
      TAP_SHIFT_IR   = 16'h0800,
      TAP_EXIT1_IR   = 16'h1000,
      TAP_PAUSE_IR   = 16'h2000,
      TAP_EXIT2_IR   = 16'h4000,
      TAP_UPD_IR     = 16'h8000
   } tap_state_t;

   localparam int         IR_W          = 5;
   localparam logic [4:0] IR_RESET      = 5'h01;
   localparam logic [4:0] IR_BYPASS     = 5'h1f;
   localparam logic [4:0] IR_IMPL       = 5'h03;
   localparam logic [1:0] IR_CAPTURE    = 2'h1;
   localparam int         IMPL_W        = 32;
   localparam int         IMPL_PROBE_DEBUG_IRQ_BIT = 24;
   localparam int         SYNC_STAGES   = 3;

   // test port outputs travel together
   typedef struct packed {
      logic tdo;
      logic tdo_float;
   } tap_out_t;

endpackage

/* File: rtl/dbg_tap_top.sv */
// debug test port pins and debug interrupt edge detection
`timescale 1ns/1ns
`default_nettype none
// How it works
// - a low test reset forces the test port controller into its reset state.
// - the float output is 1 to leave test data out undriven and 0 to drive it.
// - a strap sets the debug interrupt supported bit that the probe can read.
// - a debug interrupt fires, when supported, once stages two and three agree high after a low level.
module dbg_tap_top
   import dbg_tap_pkg::*;
(
   // cpu clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // test port from the probe
   input  wire logic dbg_test_clock_in,
   input  wire logic dbg_test_reset_n,
   input  wire logic dbg_test_mode_sel_in,
   input  wire logic dbg_test_data_in,
   // test port back to the chip level
   output logic      dbg_test_data_out,
   output logic      dbg_test_out_float,
   // debug interrupt
   input  wire logic dbg_irq_supported_strap,
   input  wire logic dbg_irq_request,
   output logic      dbg_irq_supported_bit,
   output logic      probe_debug_irq
);

   logic [SYNC_STAGES-1:0] irq_sync_ff;
   logic                   irq_level_ff;
   logic                   irq_pulse_ff;
   logic                   sup_ff;
   logic [1:0]             sup_tck_ff;
   tap_out_t               tap_out;

   // debug interrupt: three stages, level changes when stages two and three agree
   wire irq_agree = (irq_sync_ff[1] == irq_sync_ff[2]);
   wire irq_rise  = irq_agree && irq_sync_ff[2] && !irq_level_ff;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_sync_ff  <= '0;
         irq_level_ff <= 1'b0;
         irq_pulse_ff <= 1'b0;
         sup_ff       <= 1'b0;
      end else begin
         irq_sync_ff  <= {irq_sync_ff[1:0], dbg_irq_request};
         if (irq_agree) begin
            irq_level_ff <= irq_sync_ff[2];
         end
         irq_pulse_ff <= irq_rise && sup_ff;
         sup_ff       <= dbg_irq_supported_strap;
      end
   end

   // static strap crossed into the test clock domain; two stages suffice for a level
   always_ff @(posedge dbg_test_clock_in or negedge dbg_test_reset_n) begin
      if (!dbg_test_reset_n) begin
         sup_tck_ff <= '0;
      end else begin
         sup_tck_ff <= {sup_tck_ff[0], sup_ff};
      end
   end

   dbg_tap_ctrl u_ctrl (
      .dbg_test_clock_in    (dbg_test_clock_in),
      .dbg_test_reset_n     (dbg_test_reset_n),
      .dbg_test_mode_sel_in (dbg_test_mode_sel_in),
      .dbg_test_data_in     (dbg_test_data_in),
      .impl_probe_debug_irq_sup        (sup_tck_ff[1]),
      .tap_out              (tap_out)
   );

   // core never presents a three-state pin, only the float indication
   assign dbg_test_data_out     = tap_out.tdo;
   assign dbg_test_out_float    = tap_out.tdo_float;
   assign dbg_irq_supported_bit = sup_ff;
   assign probe_debug_irq       = irq_pulse_ff;

   // a pulse lasts no more than one mclk cycle
   irq_single_a: assert property (@(posedge mclk) disable iff (reset)
      probe_debug_irq |=> !probe_debug_irq) else $error("irq pulse too long");
   // a pulse needs the supported bit and a prior low level
   irq_cause_a: assert property (@(posedge mclk) disable iff (reset)
      probe_debug_irq |-> $past(sup_ff) && !$past(irq_level_ff)) else $error("bad irq");
   // supported bit follows the strap one cycle later
   strap_track_a: assert property (@(posedge mclk) disable iff (reset)
      ##1 dbg_irq_supported_bit == $past(dbg_irq_supported_strap)) else $error("strap");
   // test reset puts the port in float at once, the reset is asynchronous
   trst_float_a: assert property (@(posedge mclk)
      !dbg_test_reset_n |-> dbg_test_out_float) else $error("float after reset");

endmodule
`default_nettype wire
